// file: design/display_scan_defines.vh
// Constants for the segment display scan-timing core
`ifndef DISPLAY_SCAN_DEFINES_VH
`define DISPLAY_SCAN_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_DIV_LOW 32'h0000a120
`define IDX_DIV_HIGH 32'h0000a121
`define IDX_PIN_CFG 32'h0000a122
`define IDX_SCAN_CFG 32'h0000a123

// Reset values
`define RST_DIV_LOW 8'h00
`define RST_DIV_HIGH 8'h00
`define RST_PIN_CFG 8'h00
`define RST_SCAN_CFG 8'h00

// High divider register fields
`define HI_CLK_SRC 7
`define HI_MODE_HI 6
`define HI_MODE_LO 5
`define HI_BRT2 4
`define HI_DIV_HI 3

// Pin and frame configuration fields
`define PC_COM7 7
`define PC_COM4 4
`define PC_BLANK 3
`define PC_IRQEN 1
`define PC_FLAG 0
`define PC_WMASK 8'hfa

// Scan configuration fields
`define SC_BIAS_HI 7
`define SC_BIAS_LO 6
`define SC_BRT_HI 5
`define SC_BRT_LO 4
`define SC_DUTY_HI 3

// Modes
`define MODE_OFF 2'h0
`define MODE_LCD 2'h1
`define MODE_LED_EXT 2'h2
`define MODE_LED_DIR 2'h3

// Timing counts
`define LED_PRESCALE 9'h100
`define MAX_DUTY_PHASES 4'h8

`endif

// file: design/pixel_divider.v
// Programmable divider that turns source ticks into pixel ticks
`timescale 1ns/1ps
module pixel_divider (
	input wire pclk,
	input wire presetn,
	input wire run,
	input wire src_tick,
	input wire [11:0] divide_value,
	output reg pixel_tick
);
	reg [11:0] count_reg;

	// One pixel tick every divide_value+1 source ticks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 12'h000;
			pixel_tick <= 1'b0;
		end else if (!run) begin
			count_reg <= 12'h000;
			pixel_tick <= 1'b0;
		end else if (src_tick) begin
			if (count_reg >= divide_value) begin
				count_reg <= 12'h000;
				pixel_tick <= 1'b1;
			end else begin
				count_reg <= count_reg + 12'h001;
				pixel_tick <= 1'b0;
			end
		end else begin
			pixel_tick <= 1'b0;
		end
	end
endmodule // pixel_divider

// file: design/display_scan_core.v
// Segment display scan-timing core with APB register access
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "display_scan_defines.vh"
module display_scan_core (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire rtc_tick,
	input wire internal_fast_oscillator,
	input wire low_power_stop,
	input wire [31:0] segment_pattern,
	output reg [27:0] segment_out,
	output reg [3:0] common_out,
	output reg [3:0] shared_pin_out,
	output reg [1:0] bias_select,
	output reg [2:0] brightness_level,
	output reg [2:0] scan_phase,
	output reg frame_irq
);
	localparam ST_IDLE = 3'b001;
	localparam ST_SCAN = 3'b010;
	localparam ST_HOLD = 3'b100;

	reg [7:0] div_low_reg;
	reg [7:0] div_high_reg;
	reg [7:0] pin_cfg_reg;
	reg [7:0] scan_cfg_reg;
	reg clear_pending_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [7:0] prescale_reg;
	reg [2:0] phase_reg;
	reg [7:0] commons;
	reg [7:0] rdata;
	reg hit;

	wire [1:0] mode;
	wire led_mode;
	wire display_tick;
	wire src_tick;
	wire pixel_tick;
	wire frame_end;
	wire [11:0] pixel_divider_full;
	wire [3:0] duty_select;
	wire [3:0] phase_total;
	wire access;
	wire wr_en;
	wire wr_div_low;
	wire wr_div_high;
	wire wr_pin_cfg;
	wire wr_scan_cfg;
	wire sel_div_low;
	wire sel_div_high;
	wire sel_pin_cfg;
	wire sel_scan_cfg;
	wire [7:0] pin_wmask;
	wire prescale_wrap;
	wire scanning;

	// Phases in one frame for the given mode and duty or digit code
	function [3:0] phases_of;
		input [1:0] md;
		input [3:0] code;
		begin
			if (md == `MODE_LED_DIR)
				phases_of = (code >= `MAX_DUTY_PHASES) ? `MAX_DUTY_PHASES : code + 4'h1;
			else if (code >= `MAX_DUTY_PHASES)
				phases_of = `MAX_DUTY_PHASES;
			else
				phases_of = code + 4'h1;
		end
	endfunction

	// Register index match at word-aligned byte address
	function addr_is;
		input [31:0] addr;
		input [31:0] idx;
		begin
			addr_is = (addr == {idx[29:0], 2'b00});
		end
	endfunction

	// Shared pin shows its common line when enabled, else its segment
	function shared_pick;
		input en;
		input com;
		input seg;
		begin
			shared_pick = en ? com : seg;
		end
	endfunction

	assign mode = div_high_reg[`HI_MODE_HI:`HI_MODE_LO];
	assign led_mode = mode[1];
	assign pixel_divider_full = {div_high_reg[`HI_DIV_HI:0], div_low_reg};
	assign duty_select = scan_cfg_reg[`SC_DUTY_HI:0];
	assign phase_total = phases_of(mode, duty_select);

	// Display clock edge: LCD picks its source, LED uses the system clock
	assign display_tick = led_mode ? 1'b1 :
		(div_high_reg[`HI_CLK_SRC] ? internal_fast_oscillator : rtc_tick);

	// LED modes add a fixed divide by 256 ahead of the divider
	assign prescale_wrap = ({1'b0, prescale_reg} == `LED_PRESCALE - 9'h001);
	assign src_tick = led_mode ? prescale_wrap : display_tick;

	assign access = psel & penable & pready;
	assign wr_en = access & pwrite & hit;

	// Register selects and write strobes
	assign sel_div_low = addr_is(paddr, `IDX_DIV_LOW);
	assign sel_div_high = addr_is(paddr, `IDX_DIV_HIGH);
	assign sel_pin_cfg = addr_is(paddr, `IDX_PIN_CFG);
	assign sel_scan_cfg = addr_is(paddr, `IDX_SCAN_CFG);
	assign wr_div_low = wr_en & sel_div_low;
	assign wr_div_high = wr_en & sel_div_high;
	assign wr_pin_cfg = wr_en & sel_pin_cfg;
	assign wr_scan_cfg = wr_en & sel_scan_cfg;
	assign pin_wmask = `PC_WMASK;
	assign scanning = (state_reg == ST_SCAN);

	always @* begin
		hit = 1'b1;
		rdata = 8'h00;
		if (sel_div_low)
			rdata = div_low_reg;
		else if (sel_div_high)
			rdata = div_high_reg;
		else if (sel_pin_cfg)
			rdata = {pin_cfg_reg[7:3], 1'b0, pin_cfg_reg[1:0]};
		else if (sel_scan_cfg)
			rdata = scan_cfg_reg;
		else
			hit = 1'b0;
	end

	// APB slave: one wait state, unmapped addresses answer with an error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= ~hit;
			prdata <= {24'h000000, rdata};
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
	end

	// Configuration registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_low_reg <= `RST_DIV_LOW;
			div_high_reg <= `RST_DIV_HIGH;
			scan_cfg_reg <= `RST_SCAN_CFG;
		end else if (wr_en) begin
			if (wr_div_low)
				div_low_reg <= pwdata[7:0];
			if (wr_div_high)
				div_high_reg <= pwdata[7:0];
			if (wr_scan_cfg)
				scan_cfg_reg <= pwdata[7:0];
		end
	end

	// Pin config and frame flag; a pending clear lands on the next display edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_cfg_reg <= `RST_PIN_CFG;
			clear_pending_reg <= 1'b0;
		end else begin
			if (wr_pin_cfg)
				pin_cfg_reg[7:1] <= pwdata[7:1] & pin_wmask[7:1];
			if (frame_end) begin
				pin_cfg_reg[`PC_FLAG] <= 1'b1;
				clear_pending_reg <= 1'b0;
			end else if (clear_pending_reg && display_tick) begin
				pin_cfg_reg[`PC_FLAG] <= 1'b0;
				clear_pending_reg <= 1'b0;
			end
			if (wr_pin_cfg && !pwdata[`PC_FLAG] && !frame_end)
				clear_pending_reg <= 1'b1;
		end
	end

	// Scan state: idle when off, held while LED clocks stop in low power
	always @* begin
		case (state_reg)
			ST_IDLE: state_next = (mode != `MODE_OFF) ? ST_SCAN : ST_IDLE;
			ST_SCAN: begin
				if (mode == `MODE_OFF)
					state_next = ST_IDLE;
				else if (low_power_stop && led_mode)
					state_next = ST_HOLD;
				else
					state_next = ST_SCAN;
			end
			ST_HOLD: begin
				if (mode == `MODE_OFF)
					state_next = ST_IDLE;
				else if (!(low_power_stop && led_mode))
					state_next = ST_SCAN;
				else
					state_next = ST_HOLD;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Fixed LED prescaler
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prescale_reg <= 8'h00;
		else if (scanning && led_mode)
			prescale_reg <= prescale_reg + 8'h01;
		else
			prescale_reg <= 8'h00;
	end

	pixel_divider u_pixel_divider (
		.pclk(pclk),
		.presetn(presetn),
		.run(scanning),
		.src_tick(src_tick),
		.divide_value(pixel_divider_full),
		.pixel_tick(pixel_tick)
	);

	// Frame ends on the pixel tick that closes the last phase
	assign frame_end = pixel_tick && ({1'b0, phase_reg} + 4'h1 >= phase_total);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phase_reg <= 3'h0;
		else if (state_reg == ST_IDLE)
			phase_reg <= 3'h0;
		else if (frame_end)
			phase_reg <= 3'h0;
		else if (pixel_tick)
			phase_reg <= phase_reg + 3'h1;
	end

	always @* begin
		commons = 8'h00;
		if (state_reg != ST_IDLE)
			commons[phase_reg] = 1'b1;
	end

	// Pin drive, blanked outputs go inactive while scanning continues
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			segment_out <= 28'h0000000;
			common_out <= 4'h0;
			shared_pin_out <= 4'h0;
		end else if (pin_cfg_reg[`PC_BLANK] || state_reg == ST_IDLE) begin
			segment_out <= 28'h0000000;
			common_out <= 4'h0;
			shared_pin_out <= 4'h0;
		end else begin
			segment_out <= segment_pattern[27:0];
			common_out <= commons[3:0];
			shared_pin_out[0] <= shared_pick(pin_cfg_reg[`PC_COM7], commons[7], segment_pattern[28]);
			shared_pin_out[1] <= shared_pick(pin_cfg_reg[6], commons[6], segment_pattern[29]);
			shared_pin_out[2] <= shared_pick(pin_cfg_reg[5], commons[5], segment_pattern[30]);
			shared_pin_out[3] <= shared_pick(pin_cfg_reg[`PC_COM4], commons[4], segment_pattern[31]);
		end
	end

	// Analog settings and status outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bias_select <= 2'h0;
			brightness_level <= 3'h0;
			scan_phase <= 3'h0;
			frame_irq <= 1'b0;
		end else begin
			bias_select <= scan_cfg_reg[`SC_BIAS_HI:`SC_BIAS_LO];
			brightness_level <= {div_high_reg[`HI_BRT2], scan_cfg_reg[`SC_BRT_HI:`SC_BRT_LO]};
			scan_phase <= phase_reg;
			frame_irq <= pin_cfg_reg[`PC_FLAG] & pin_cfg_reg[`PC_IRQEN];
		end
	end
endmodule // display_scan_core

// file: verification/tick_source.sv
// Panel side clock model: real-time and fast oscillator tick pulses
`timescale 1ns/1ps
module tick_source #(parameter int RP = 7, parameter int FP = 3) (
	input wire logic pclk,
	input wire logic presetn,
	output logic rtc_tick,
	output logic osc_tick
);
	int rc;
	int fc;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc <= 0;
			fc <= 0;
		end else begin
			rc <= (rc == RP - 1) ? 0 : rc + 1;
			fc <= (fc == FP - 1) ? 0 : fc + 1;
		end
	end
	assign rtc_tick = presetn && rc == RP - 1;
	assign osc_tick = presetn && fc == FP - 1;
endmodule // tick_source

// file: verification/display_scan_asserts.sv
// Port-level checks for the display scan core
`timescale 1ns/1ps
module display_scan_asserts (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [31:0] segment_pattern,
	input wire [27:0] segment_out,
	input wire [3:0] common_out,
	input wire [2:0] scan_phase,
	input wire [2:0] brightness_level,
	input wire [1:0] bias_select
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PREADY_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not after one wait state");
	AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	AST_PREADY_ACCESS: assert property (pready |-> psel && penable) else $error("pready outside access");
	AST_ERR_DATA: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
	AST_READ_PAD: assert property (pready |-> prdata[31:8] == 24'h0) else $error("read data upper bits set");
	AST_COMMON_ONEHOT: assert property ($onehot0(common_out)) else $error("common lines not one-hot");
	AST_COMMON_PHASE: assert property (common_out != 4'h0 |-> common_out == 4'h1 << scan_phase)
		else $error("active common does not match scan phase");
	AST_PHASE_STEP: assert property ($changed(scan_phase) |-> scan_phase == 3'h0 ||
		scan_phase == $past(scan_phase) + 3'h1) else $error("scan phase skipped");
	AST_SEG_SOURCE: assert property ((segment_out & ~($past(segment_pattern[27:0]) |
		$past(segment_pattern[27:0], 2))) == 28'h0) else $error("segment bit without pattern");
	AST_BRT_WRITE: assert property ($changed({brightness_level, bias_select}) |->
		$past(pwrite && pready) || $past(pwrite && pready, 2)) else $error("drive setting changed alone");
endmodule // display_scan_asserts

// file: verification/display_scan_core_tb.sv
// Self-checking bench for the display scan core
`timescale 1ns/1ps
`include "display_scan_defines.vh"
module display_scan_core_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, low_power_stop = 0, err;
	logic [31:0] paddr = 0, pwdata = 0, segment_pattern = 0, prdata, rd, pat, t0, t1;
	logic pready, pslverr, rtc_tick, osc_tick, frame_irq;
	logic [27:0] segment_out;
	logic [3:0] common_out, shared_pin_out;
	logic [1:0] bias_select;
	logic [2:0] brightness_level, scan_phase;
	logic [7:0] hv[6] = '{8'h20, 8'ha0, 8'hc0, 8'h60, 8'h40, 8'ha0};
	int lv[6] = '{1, 4, 0, 0, 1, 20};
	int sv[6] = '{1, 1, 1, 2, 7, 0};
	integer seed = 32'h10a606a5;
	int n_mismatch = 0, check_count = 0, cyc = 0, ex, m[4];
	initial forever #5 pclk = ~pclk;
	tick_source src_u (.pclk(pclk), .presetn(presetn), .rtc_tick(rtc_tick), .osc_tick(osc_tick));
	display_scan_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rtc_tick(rtc_tick),
		.internal_fast_oscillator(osc_tick), .low_power_stop(low_power_stop), .segment_pattern(segment_pattern),
		.segment_out(segment_out), .common_out(common_out), .shared_pin_out(shared_pin_out),
		.bias_select(bias_select), .brightness_level(brightness_level), .scan_phase(scan_phase),
		.frame_irq(frame_irq));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= idx * 4;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [31:0] idx, input logic [31:0] wd);
		apb(1, idx, wd);
		m[idx - `IDX_DIV_LOW] = (idx == `IDX_PIN_CFG) ? wd & `PC_WMASK : wd & 32'hff;
	endtask
	task automatic wait_rise(output logic [31:0] t);
		while (frame_irq !== 1'b0) @(posedge pclk);
		while (frame_irq !== 1'b1) @(posedge pclk);
		t = cyc;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 4; i++) begin
			apb(0, `IDX_DIV_LOW + i, 0);
			chk("reset value", 0, rd);
		end
		apb(0, 32'h0, 0);
		chk("unmapped error", 1, err);
		$display("test reset done");
		wr(`IDX_DIV_LOW, $random(seed));
		wr(`IDX_DIV_HIGH, $random(seed) & 32'h9f);
		wr(`IDX_PIN_CFG, $random(seed) | 32'h1);
		wr(`IDX_SCAN_CFG, $random(seed));
		for (int i = 0; i < 4; i++) begin
			apb(0, `IDX_DIV_LOW + i, 0);
			chk("readback", m[i], rd);
		end
		chk("bias", m[3][7:6], bias_select);
		chk("brightness", {m[1][4], m[3][5:4]}, brightness_level);
		$display("test registers done");
		pat = $random(seed) | 32'hf0000000;
		segment_pattern <= pat;
		wr(`IDX_SCAN_CFG, 1);
		wr(`IDX_PIN_CFG, 0);
		wr(`IDX_DIV_HIGH, 32'h40);
		repeat (3) @(posedge pclk);
		chk("segments", pat[27:0], segment_out);
		chk("shared segments", pat[31:28], shared_pin_out);
		wr(`IDX_PIN_CFG, 32'hf0);
		repeat (3) @(posedge pclk);
		chk("shared commons", 0, shared_pin_out);
		wr(`IDX_PIN_CFG, 32'h08);
		repeat (3) @(posedge pclk);
		chk("blanked", 0, {common_out, segment_out});
		chk("blanked shared", 0, shared_pin_out);
		$display("test pins done");
		for (int r = 0; r < 6; r++) begin
			low_power_stop <= (hv[r][6:5] == `MODE_LCD);
			wr(`IDX_SCAN_CFG, sv[r]);
			wr(`IDX_DIV_LOW, lv[r]);
			wr(`IDX_DIV_HIGH, hv[r]);
			wr(`IDX_PIN_CFG, 32'h02);
			wait_rise(t0);
			wr(`IDX_PIN_CFG, 32'h02);
			wait_rise(t0);
			wr(`IDX_PIN_CFG, 32'h02);
			wait_rise(t1);
			ex = ((hv[r][6:5] == `MODE_LCD) ? (hv[r][7] ? 3 : 7) : 256) * (lv[r] + 1) * (sv[r] + 1);
			chk("frame period", ex, t1 - t0);
		end
		$display("test frames done");
		give_verdict();
	end
endmodule // display_scan_core_tb
bind display_scan_core display_scan_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.segment_pattern(segment_pattern), .segment_out(segment_out), .common_out(common_out),
	.scan_phase(scan_phase), .brightness_level(brightness_level), .bias_select(bias_select));
